// >>> rtl/wrs_supervisor.sv
/*
 * wrs_supervisor: supervisory logic of a wireless power receiver.
 * assumes comparator levels and adc strobes synchronous to CLK.
 */
// Operation
// - rectifier target is vout plus offset picked by load fraction
// - rectifier moved only by requests sent to the transmitter
// - over-voltage comparator raises an interrupt
// - over-voltage drives the coil clamp
// - termination packet uses header 0x02 then one reason byte
// - reason 0x00 on adapter, 0x01 on sense below 0.3 V
// - reason 0x02 when die temperature passes the shutoff limit
// - over-voltage sends 0x03, never 0x04
// - reasons 0x05, 0x06, 0x07 are never sent
// - reason 0x08 if rectifier never reaches 6.5 V
// - thermistor below 1 V ends transfer and stops output
// - thermistor decision uses the adc result
// - adapter detected drives path enable low
// - adapter detection flagged and ends power transfer
// - adapter removed drives path enable high
// - charging indicator high while output current flows
// - adc sweeps eight inputs, results to the logic
`timescale 1ns/1ps
module wrs_supervisor #(
    parameter int REACH_CYC = wrs_pkg::REACH_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // comparators
    input wire logic RECTIFIER_OVERVOLTAGE_FLAG,
    input wire logic ADAPTER_DETECT,
    input wire logic ADAPTER_REMOVED,
    // adc
    output logic ADC_START,
    output logic [2:0] ADC_CHANNEL,
    input wire logic ADC_DONE,
    input wire logic [11:0] ADC_RESULT,
    // link modulator
    output wrs_pkg::wrs_pkt_t TX_PKT,
    input wire logic TX_READY,
    // power path
    output logic COIL_CLAMP_DRIVE,
    output logic ADAPTER_PATH_EN_N,
    output logic OUTPUT_ENABLE,
    output logic CHARGING_INDICATOR,
    output logic IRQ
);
    // every check below runs on CLK and rests while reset is held
    default clocking chk_cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    if (REACH_CYC < 1 || REACH_CYC > 32'h0FFF_FFFF)
    begin : g_chk
        $error("REACH_CYC out of range");
    end

    function automatic logic [11:0] mv2c(input int mv);
        mv2c = 12'((mv * 1000) / wrs_pkg::LSB_UV);
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic run_q, ept_done_q, swept_q, busy_q, clamp_q, en_n_q;
    logic ovp_prev_q, start_q, oen_q, chg_q, irq_q, kind_q;
    logic [2:0] ch_q;
    logic [3:0] sts_q, mask_q;
    logic [11:0] imax_q, vout_q, die_q;
    logic [11:0] res_q [8];
    logic [27:0] tmr_q;
    logic [7:0] reason_q, body_q;
    logic [15:0] rdata_q;
    wrs_pkg::wrs_pkt_t pkt_q;
    wrs_pkg::wrs_tx_t st_q;

    // ****************************************
    // register decode
    // ****************************************
    wire wr_ctrl = REG_WR && REG_ADDR == wrs_pkg::A_CTRL;
    wire wr_stat = REG_WR && REG_ADDR == wrs_pkg::A_STAT;
    wire restart = wr_ctrl && REG_WDATA[wrs_pkg::B_RESTART];
    wire [15:0] rd_val =
        REG_ADDR[3] ? {4'h0, res_q[REG_ADDR[2:0]]} :
        REG_ADDR == wrs_pkg::A_CTRL ? {15'h0000, run_q} :
        REG_ADDR == wrs_pkg::A_STAT ? {12'h000, sts_q} :
        REG_ADDR == wrs_pkg::A_MASK ? {12'h000, mask_q} :
        REG_ADDR == wrs_pkg::A_IMAX ? {4'h0, imax_q} :
        REG_ADDR == wrs_pkg::A_VOUT ? {4'h0, vout_q} :
        REG_ADDR == wrs_pkg::A_DIE ? {4'h0, die_q} :
        REG_ADDR == wrs_pkg::A_EPT ? {7'h00, ept_done_q, reason_q} :
        16'h0000;

    // ****************************************
    // adc sweep
    // ****************************************
    wire adc_take = busy_q && ADC_DONE;
    wire sweep_end = adc_take && ch_q == 3'h7;

    // ****************************************
    // termination conditions and priority
    // ****************************************
    wire [11:0] ts = res_q[wrs_pkg::CH_TS];
    wire [11:0] rect = res_q[wrs_pkg::CH_RECT];
    wire [11:0] iout = res_q[wrs_pkg::CH_IOUT];
    wire die_hot = swept_q && res_q[wrs_pkg::CH_DIE] > die_q;
    wire ts_done = swept_q && ts < mv2c(wrs_pkg::TS_DONE_MV);
    wire ts_hot = swept_q && ts < mv2c(wrs_pkg::TS_HOT_MV);
    wire rectifier_overvoltage_flag = RECTIFIER_OVERVOLTAGE_FLAG;
    wire adp = !en_n_q;
    wire timed_out = tmr_q == 28'(REACH_CYC);
    wire no_resp = timed_out && rect < mv2c(wrs_pkg::RECT_MIN_MV);
    wire term = die_hot || ts_done || ts_hot || rectifier_overvoltage_flag || adp || no_resp;
    // fixed priority, only listed codes reachable
    wire [7:0] why = die_hot ? wrs_pkg::EPT_FAULT :
        ts_done ? wrs_pkg::EPT_DONE :
        (ts_hot || rectifier_overvoltage_flag) ? wrs_pkg::EPT_HOT :
        adp ? wrs_pkg::EPT_UNKNOWN :
        wrs_pkg::EPT_NORESP;
    wire live = run_q && !ept_done_q;
    wire send_ept = live && term && st_q == wrs_pkg::TX_IDLE;
    wire send_ce = live && !term && sweep_end &&
        st_q == wrs_pkg::TX_IDLE;

    // ****************************************
    // rectifier target and control error
    // ****************************************
    wire [15:0] i10 = 16'(iout) * 16'd10;
    wire [15:0] i5 = 16'(iout) * 16'd5;
    wire [15:0] im2 = {3'b000, imax_q, 1'b0};
    wire [11:0] ofs = i10 < 16'(imax_q) ? mv2c(wrs_pkg::OFS0_MV) :
        i5 < 16'(imax_q) ? mv2c(wrs_pkg::OFS1_MV) :
        i5 < im2 ? mv2c(wrs_pkg::OFS2_MV) :
        mv2c(wrs_pkg::OFS3_MV);
    wire signed [13:0] err = 14'(vout_q) + 14'(ofs) - 14'(rect);
    wire [7:0] ce_byte = err > 14'sd127 ? 8'h7F :
        err < -14'sd128 ? 8'h80 : err[7:0];

    // ****************************************
    // events and interrupt
    // ****************************************
    wire ept_fin = st_q == wrs_pkg::TX_BODY && TX_READY && kind_q;
    wire adp_on = en_n_q && ADAPTER_DETECT;
    wire [3:0] ev = {sweep_end, ept_fin, adp_on,
        rectifier_overvoltage_flag && !ovp_prev_q};
    wire [3:0] clr = wr_stat ? REG_WDATA[3:0] : 4'h0;
    wire [3:0] sts_d = (sts_q & ~clr) | ev; // set wins over clear

    // software registers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            run_q <= 1'b0;
            mask_q <= 4'h0;
            imax_q <= wrs_pkg::R_IMAX;
            vout_q <= wrs_pkg::R_VOUT;
            die_q <= wrs_pkg::R_DIE;
            sts_q <= 4'h0;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl)
                run_q <= REG_WDATA[wrs_pkg::B_RUN];
            if (REG_WR && REG_ADDR == wrs_pkg::A_MASK)
                mask_q <= REG_WDATA[3:0];
            if (REG_WR && REG_ADDR == wrs_pkg::A_IMAX)
                imax_q <= REG_WDATA[11:0];
            if (REG_WR && REG_ADDR == wrs_pkg::A_VOUT)
                vout_q <= REG_WDATA[11:0];
            if (REG_WR && REG_ADDR == wrs_pkg::A_DIE)
                die_q <= REG_WDATA[11:0];
            sts_q <= sts_d;
            irq_q <= |(sts_q & mask_q);
            rdata_q <= REG_RD ? rd_val : 16'h0000;
        end
    end

    // adc channel walk, one result per done
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ch_q <= 3'h0;
            busy_q <= 1'b0;
            start_q <= 1'b0;
            swept_q <= 1'b0;
        end
        else
        begin
            start_q <= !busy_q && !start_q;
            if (start_q)
                busy_q <= 1'b1;
            if (adc_take)
            begin
                busy_q <= 1'b0;
                ch_q <= ch_q + 3'h1;
            end
            if (sweep_end)
                swept_q <= 1'b1;
        end
    end

    // result store
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            res_q <= '{default: 12'h000};
        else if (adc_take)
            res_q[ch_q] <= ADC_RESULT;
    end

    // power path, clamp and reach timer
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            clamp_q <= 1'b0;
            ovp_prev_q <= 1'b0;
            en_n_q <= 1'b1;
            oen_q <= 1'b0;
            chg_q <= 1'b0;
            tmr_q <= 28'h000_0000;
        end
        else
        begin
            clamp_q <= rectifier_overvoltage_flag;
            ovp_prev_q <= rectifier_overvoltage_flag;
            if (ADAPTER_DETECT)
                en_n_q <= 1'b0;
            else if (ADAPTER_REMOVED)
                en_n_q <= 1'b1;
            oen_q <= live && !term;
            chg_q <= live && !term && iout != 12'h000;
            if (!run_q || restart)
                tmr_q <= 28'h000_0000;
            else if (!timed_out)
                tmr_q <= tmr_q + 28'h000_0001;
        end
    end

    // packet sender, header then one body byte
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_q <= wrs_pkg::TX_IDLE;
            pkt_q <= '0;
            kind_q <= 1'b0;
            body_q <= 8'h00;
            reason_q <= 8'h00;
            ept_done_q <= 1'b0;
        end
        else
        begin
            if (restart)
                ept_done_q <= 1'b0;
            unique case (st_q)
                wrs_pkg::TX_IDLE:
                begin
                    if (send_ept || send_ce)
                    begin
                        st_q <= wrs_pkg::TX_HDR;
                        kind_q <= send_ept;
                        pkt_q <= '{valid: 1'b1, last: 1'b0,
                            data: send_ept ? wrs_pkg::H_EPT :
                            wrs_pkg::H_CE};
                        body_q <= send_ept ? why : ce_byte;
                        if (send_ept)
                            reason_q <= why;
                    end
                end
                wrs_pkg::TX_HDR:
                begin
                    if (TX_READY)
                    begin
                        st_q <= wrs_pkg::TX_BODY;
                        pkt_q <= '{valid: 1'b1, last: 1'b1,
                            data: body_q};
                    end
                end
                wrs_pkg::TX_BODY:
                begin
                    if (TX_READY)
                    begin
                        st_q <= wrs_pkg::TX_IDLE;
                        pkt_q <= '0;
                        if (kind_q)
                            ept_done_q <= 1'b1;
                    end
                end
                default:
                    st_q <= wrs_pkg::TX_IDLE;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign REG_RDATA = rdata_q;
    assign ADC_START = start_q;
    assign ADC_CHANNEL = ch_q;
    assign TX_PKT = pkt_q;
    assign COIL_CLAMP_DRIVE = clamp_q;
    assign ADAPTER_PATH_EN_N = en_n_q;
    assign OUTPUT_ENABLE = oen_q;
    assign CHARGING_INDICATOR = chg_q;
    assign IRQ = irq_q;

    // ****************************************
    // checks
    // ****************************************
    // clamp follows the comparator both ways
    a_clamp_on_ovp: assert property (rectifier_overvoltage_flag |=> COIL_CLAMP_DRIVE)
        else $error("clamp not driven on over-voltage");
    a_clamp_release: assert property (!rectifier_overvoltage_flag |=> !COIL_CLAMP_DRIVE)
        else $error("clamp left on without over-voltage");
    // over-voltage and adapter flags, interrupt level
    a_ovp_irq_flag: assert property (
        $rose(rectifier_overvoltage_flag) |=> sts_q[wrs_pkg::E_OVP])
        else $error("over-voltage flag not set");
    a_irq_level: assert property (
        |(sts_q & mask_q) |=> IRQ)
        else $error("interrupt not raised for unmasked flag");
    a_adp_flag: assert property (
        adp_on |=> sts_q[wrs_pkg::E_ADP])
        else $error("adapter flag not set");
    // termination packet: header, body and legal reasons
    a_ept_header: assert property (
        send_ept |=> TX_PKT.valid && TX_PKT.data == 8'h02)
        else $error("bad termination header");
    a_ept_body: assert property (
        st_q == wrs_pkg::TX_BODY && kind_q |->
        TX_PKT.valid && TX_PKT.last && TX_PKT.data == reason_q)
        else $error("termination body does not carry the reason");
    a_reason_legal: assert property (
        st_q == wrs_pkg::TX_BODY && kind_q |->
        TX_PKT.data inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h08})
        else $error("forbidden reason sent");
    // adapter path follows the two comparators
    a_adapter_on: assert property (
        ADAPTER_DETECT |=> !ADAPTER_PATH_EN_N)
        else $error("adapter path not enabled");
    a_adapter_off: assert property (
        ADAPTER_REMOVED && !ADAPTER_DETECT |=> ADAPTER_PATH_EN_N)
        else $error("adapter path not cut");
    // one termination per restart, output off afterwards
    a_one_ept: assert property (
        ept_done_q && !restart |=>
        !(st_q == wrs_pkg::TX_HDR && kind_q))
        else $error("second termination packet");
    a_chg_stops: assert property (
        ept_done_q ##1 ept_done_q |->
        !CHARGING_INDICATOR && !OUTPUT_ENABLE)
        else $error("output still on after termination");
    a_chg_has_out: assert property (
        CHARGING_INDICATOR |-> OUTPUT_ENABLE)
        else $error("charging shown with output off");
    // adc walk advances one channel per result
    a_adc_walk: assert property (
        adc_take |=> ch_q == $past(ch_q) + 3'h1 ##1 ADC_START)
        else $error("adc channel did not advance");
endmodule

// >>> rtl/wrs_pkg.sv
/*
 * wrs_pkg: constants and types of the wireless receiver supervisor.
 * assumes adc codes of 12 bits with a fixed weight per code.
 */
package wrs_pkg;
    // ****************************************
    // register map (4-bit word address)
    // ****************************************
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STAT = 4'h1;
    localparam logic [3:0] A_MASK = 4'h2;
    localparam logic [3:0] A_IMAX = 4'h3;
    localparam logic [3:0] A_VOUT = 4'h4;
    localparam logic [3:0] A_DIE = 4'h5;
    localparam logic [3:0] A_EPT = 4'h6;
    localparam logic [3:0] A_CHAN = 4'h8; // results at 8..15
    localparam int B_RUN = 0;
    localparam int B_RESTART = 1;
    localparam int E_OVP = 0;
    localparam int E_ADP = 1;
    localparam int E_EPT = 2;
    localparam int E_SWEEP = 3;
    localparam logic [11:0] R_IMAX = 12'h0_FFF;
    localparam logic [11:0] R_VOUT = 12'h0_4E2; // 5.0 V
    localparam logic [11:0] R_DIE = 12'h0_FFF;
    // ****************************************
    // packet headers and reasons
    // ****************************************
    localparam logic [7:0] H_EPT = 8'h02;
    localparam logic [7:0] H_CE = 8'h03;
    localparam logic [7:0] EPT_UNKNOWN = 8'h00;
    localparam logic [7:0] EPT_DONE = 8'h01;
    localparam logic [7:0] EPT_FAULT = 8'h02;
    localparam logic [7:0] EPT_HOT = 8'h03;
    localparam logic [7:0] EPT_NORESP = 8'h08;
    // ****************************************
    // adc channels and thresholds
    // ****************************************
    localparam logic [2:0] CH_TS = 3'h0;
    localparam logic [2:0] CH_DIE = 3'h1;
    localparam logic [2:0] CH_RECT = 3'h2;
    localparam logic [2:0] CH_IOUT = 3'h4;
    localparam int LSB_UV = 4000;
    localparam int TS_HOT_MV = 1000;
    localparam int TS_DONE_MV = 300;
    localparam int RECT_MIN_MV = 6500;
    localparam int OFS0_MV = 2000;
    localparam int OFS1_MV = 1500;
    localparam int OFS2_MV = 560;
    localparam int OFS3_MV = 120;
    localparam int CLK_HZ = 10_000_000;
    localparam int REACH_MS = 100;
    localparam int REACH_CYC = REACH_MS * (CLK_HZ / 1000);
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } wrs_pkt_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_HDR = 2'b01,
        TX_BODY = 2'b10
    } wrs_tx_t;
endpackage

// >>> verification/wrs_partner.sv
/*
 * wrs_partner: adc and link modulator facing the supervisor.
 * assumes the bench loads chan_val and reads the pkts queue.
 */
`timescale 1ns/1ps
module wrs_partner (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // adc
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    output logic adc_done,
    output logic [11:0] adc_result,
    // modulator
    input wire wrs_pkg::wrs_pkt_t tx_pkt,
    output logic tx_ready
);
    // ****************************************
    // analog side stand-in
    // ****************************************
    logic [11:0] chan_val [8];
    logic [15:0] pkts [$];
    logic [7:0] hdr_q;
    logic [2:0] ch_q;
    int wait_q;
    // conversion with random latency, result garbled outside done
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            adc_done <= 1'b0;
            adc_result <= 12'h5A5;
            wait_q <= 0;
        end
        else
        begin
            adc_done <= 1'b0;
            adc_result <= ~adc_result;
            if (adc_start)
            begin
                ch_q <= adc_channel;
                wait_q <= $urandom_range(4, 1);
            end
            else if (wait_q == 1)
            begin
                adc_done <= 1'b1;
                adc_result <= chan_val[ch_q];
            end
            if (!adc_start && wait_q != 0)
                wait_q <= wait_q - 1;
        end
    // modulator with random stalls, pairs header and body
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
            tx_ready <= 1'b0;
        else
        begin
            tx_ready <= ($urandom_range(3, 0) != 0);
            if (tx_pkt.valid && tx_ready && !tx_pkt.last)
                hdr_q <= tx_pkt.data;
            else if (tx_pkt.valid && tx_ready)
                pkts.push_back({hdr_q, tx_pkt.data});
        end
endmodule

// >>> verification/wrs_supervisor_test.sv
/*
 * wrs_supervisor_test: self-checking bench of the supervisor.
 * assumes wrs_partner as adc and modulator, a short reach timer.
 */
`timescale 1ns/1ps
module wrs_supervisor_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rectifier_overvoltage_flag = 1'b0;
    logic adp_det = 1'b0;
    logic adp_rem = 1'b1;
    logic [15:0] rdata;
    logic adc_start, adc_done, tx_ready, clamp, path_n, out_en, charging_indicator, irq;
    logic [2:0] adc_ch;
    logic [11:0] adc_res;
    wrs_pkg::wrs_pkt_t tx_pkt;
    int bad_count = 0;
    int samples_checked = 0;
    int band_lo [4] = '{0, 410, 819, 1638};
    int band_hi [4] = '{409, 818, 1637, 4095};
    // 10 MHz clock
    always #50 clk = ~clk;
    wrs_supervisor #(.REACH_CYC(50)) u_dut (.CLK(clk), .ARST_N(arst_n),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .RECTIFIER_OVERVOLTAGE_FLAG(rectifier_overvoltage_flag),
        .ADAPTER_DETECT(adp_det), .ADAPTER_REMOVED(adp_rem),
        .ADC_START(adc_start), .ADC_CHANNEL(adc_ch), .ADC_DONE(adc_done),
        .ADC_RESULT(adc_res), .TX_PKT(tx_pkt), .TX_READY(tx_ready),
        .COIL_CLAMP_DRIVE(clamp), .ADAPTER_PATH_EN_N(path_n),
        .OUTPUT_ENABLE(out_en), .CHARGING_INDICATOR(charging_indicator), .IRQ(irq));
    wrs_partner u_part (.clk(clk), .arst_n(arst_n), .adc_start(adc_start),
        .adc_channel(adc_ch), .adc_done(adc_done), .adc_result(adc_res),
        .tx_pkt(tx_pkt), .tx_ready(tx_ready));
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_sweep();
        logic [15:0] d;
        wr(wrs_pkg::A_STAT, 16'h0008);
        d = 16'h0000;
        for (int k = 0; k < 200 && d[3] !== 1'b1; k++)
            rd(wrs_pkg::A_STAT, d);
    endtask
    task automatic set_norm();
        rectifier_overvoltage_flag <= 1'b0;
        adp_det <= 1'b0;
        adp_rem <= 1'b1;
        u_part.chan_val[0] <= 12'h2EE; // thermistor 3.0 V
        u_part.chan_val[1] <= 12'h064;
        u_part.chan_val[2] <= 12'h6D6; // rectifier 7.0 V
        u_part.chan_val[3] <= 12'h4E2;
        u_part.chan_val[4] <= 12'h12C;
    endtask
    // restore quiet conditions, restart and forget old packets
    task automatic rearm();
        set_norm();
        wait_sweep();
        wait_sweep();
        wr(wrs_pkg::A_CTRL, 16'h0003);
        wr(wrs_pkg::A_CTRL, 16'h0001);
        wr(wrs_pkg::A_STAT, 16'h000F);
        u_part.pkts.delete();
    endtask
    task automatic scan(input bit judge, output int n, output logic [7:0] r);
        logic [15:0] p;
        n = 0;
        r = 8'h00;
        foreach (u_part.pkts[i])
        begin
            p = u_part.pkts[i];
            if (p[15:8] == 8'h02)
            begin
                n++;
                r = p[7:0];
                if (judge)
                    check("ept_code",
                        16'(p[7:0] inside {[4:7]}), 16'h0000);
            end
        end
    endtask
    task automatic ept_case(input logic [7:0] exp_r);
        int n;
        logic [7:0] r;
        logic [15:0] d;
        n = 0;
        for (int k = 0; k < 900 && n == 0; k++)
        begin
            @(posedge clk);
            scan(1'b0, n, r);
        end
        repeat (300) @(posedge clk);
        scan(1'b1, n, r);
        check("ept_count", 16'(n), 16'h0001);
        check("ept_reason", {8'h00, r}, {8'h00, exp_r});
        rd(wrs_pkg::A_EPT, d);
        check("ept_reg", d, {8'h01, exp_r});
    endtask
    function automatic logic [7:0] exp_err(input int iout, input int rect);
        int e;
        e = 1250 - rect + ((iout * 10 < 4095) ? 500 : (iout * 5 < 4095) ?
            375 : (iout * 5 < 8190) ? 140 : 30);
        e = (e > 127) ? 127 : (e < -128) ? -128 : e;
        return e[7:0];
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    // watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        logic [15:0] d;
        logic [15:0] p;
        int iout;
        int rect;
        void'($urandom(32'h3759_635e));
        for (int i = 5; i < 8; i++)
            u_part.chan_val[i] <= 12'($urandom_range(4095, 0));
        set_norm();
        repeat (6) @(posedge clk);
        check("path_reset", {15'h0, path_n}, 16'h0001);
        arst_n <= 1'b1;
        rd(wrs_pkg::A_IMAX, d);
        check("imax_reset", d, 16'h0FFF);
        rd(wrs_pkg::A_VOUT, d);
        check("vout_reset", d, 16'h04E2);
        rd(4'h7, d);
        check("unmapped", d, 16'h0000);
        wr(wrs_pkg::A_MASK, 16'h000F);
        rd(wrs_pkg::A_MASK, d);
        check("mask", d, 16'h000F);
        // nothing may go out on the link while run is clear
        wait_sweep();
        check("idle_quiet", 16'(u_part.pkts.size()), 16'h0000);
        rearm();
        for (int i = 0; i < 8; i++)
        begin
            rd(4'(8 + i), d);
            check("adc_chan", d, {4'h0, u_part.chan_val[i]});
        end
        // control error in each load band
        for (int b = 0; b < 4; b++)
        begin
            iout = $urandom_range(band_hi[b], band_lo[b]);
            rect = $urandom_range(1900, 1630);
            u_part.chan_val[4] <= 12'(iout);
            u_part.chan_val[2] <= 12'(rect);
            wait_sweep();
            wait_sweep();
            u_part.pkts.delete();
            wait_sweep();
            repeat (40) @(posedge clk);
            p = 16'h0000;
            foreach (u_part.pkts[i])
                if (u_part.pkts[i][15:8] == wrs_pkg::H_CE)
                    p = u_part.pkts[i];
            check("ctrl_err", p,
                {wrs_pkg::H_CE, exp_err(iout, rect)});
            check("charging", {15'h0, charging_indicator}, {15'h0, iout != 0});
            check("out_on", {15'h0, out_en}, 16'h0001);
        end
        // adapter plugged, then removed
        rearm();
        adp_det <= 1'b1;
        adp_rem <= 1'b0;
        ept_case(8'h00);
        check("path_on", {15'h0, path_n}, 16'h0000);
        rd(wrs_pkg::A_STAT, d);
        check("adp_stat", {15'h0, d[1]}, 16'h0001);
        check("ept_stat", {15'h0, d[2]}, 16'h0001);
        @(posedge clk);
        adp_det <= 1'b0;
        adp_rem <= 1'b1;
        repeat (3) @(posedge clk);
        check("path_off", {15'h0, path_n}, 16'h0001);
        // charge complete, then die fault together with it
        rearm();
        u_part.chan_val[0] <= 12'h032;
        ept_case(8'h01);
        rearm();
        wr(wrs_pkg::A_DIE, 16'h0300);
        u_part.chan_val[1] <= 12'h400;
        u_part.chan_val[0] <= 12'h032;
        ept_case(8'h02);
        wr(wrs_pkg::A_DIE, 16'h0FFF);
        // thermistor hot at 0.8 V stops the output
        rearm();
        u_part.chan_val[0] <= 12'h0C8;
        ept_case(8'h03);
        check("out_off", {15'h0, out_en}, 16'h0000);
        check("chg_off", {15'h0, charging_indicator}, 16'h0000);
        // over-voltage with clamp and masked interrupt
        rearm();
        wr(wrs_pkg::A_MASK, 16'h0000);
        rectifier_overvoltage_flag <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("clamp_on", {15'h0, clamp}, 16'h0001);
        ept_case(8'h03);
        check("irq_masked", {15'h0, irq}, 16'h0000);
        wr(wrs_pkg::A_MASK, 16'h0001);
        repeat (3) @(posedge clk);
        check("irq_on", {15'h0, irq}, 16'h0001);
        rectifier_overvoltage_flag <= 1'b0;
        repeat (3) @(posedge clk);
        check("clamp_off", {15'h0, clamp}, 16'h0000);
        wr(wrs_pkg::A_STAT, 16'h0001);
        repeat (3) @(posedge clk);
        check("irq_clear", {15'h0, irq}, 16'h0000);
        wr(wrs_pkg::A_MASK, 16'h000F);
        // rectifier held at 4 V never reaches its minimum
        rearm();
        u_part.chan_val[2] <= 12'h3E8;
        ept_case(8'h08);
        report_and_stop();
    end
endmodule
